// ---- src/ctv_top.sv ----
// Counter-value register and halted flag of the control timer unit, with an AXI4-Lite slave
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "ctv_map.svh"

module ctv_top
#(
    parameter int WSYNC = `CTV_WSYNC_STAGES,
    parameter int RSYNC = `CTV_RSYNC_STAGES
)
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Counting core side
    input wire ctv_pkg::ctv_core_evt_t coreEvt,
    input wire ctv_pkg::ctv_core_cfg_t coreCfg,
    output logic [23:0] countValue,
    output logic halted
);

    //------------------------------------------------------------
    // Field layout helpers
    //------------------------------------------------------------

    // Position of the count field's lowest bit for a resolution
    function automatic logic [4:0] fieldShift(input ctv_pkg::ctv_res_t mode);
        case (mode)
            ctv_pkg::RES_FOURBIT: fieldShift = `CTV_SHIFT_FOUR;
            ctv_pkg::RES_FIVEBIT: fieldShift = `CTV_SHIFT_FIVE;
            ctv_pkg::RES_SIXBIT: fieldShift = `CTV_SHIFT_SIX;
            default: fieldShift = `CTV_SHIFT_NORMAL;
        endcase
    endfunction

    // Bits of the 24-bit window that belong to the count field
    function automatic logic [23:0] fieldMask(input ctv_pkg::ctv_res_t mode);
        fieldMask = 24'hFFFFFF << fieldShift(mode);
    endfunction

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------

    typedef struct packed
    {
        logic [23:0] count;
        logic halt;
        ctv_pkg::ctv_wstate_t wState;
        logic awGot;
        logic wGot;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic [1:0] bResp;
        ctv_pkg::ctv_rstate_t rState;
        logic [7:0] arAddr;
        logic [31:0] rData;
        logic [1:0] rResp;
    } ctv_state_t;

    ctv_state_t state_r;
    ctv_state_t state_nxt;

    logic wStart;
    logic wLand;
    logic rStart;
    logic rLand;
    logic [23:0] mask;
    logic [4:0] shift;
    logic [23:0] merged;
    logic haltSet;
    logic haltClr;

    //------------------------------------------------------------
    // Bus handshakes
    //------------------------------------------------------------

    // Ready only when idle and enabled, so a frozen block never loses a beat
    assign s_axi_awready = ce && (state_r.wState == ctv_pkg::W_IDLE) && !state_r.awGot;
    assign s_axi_wready = ce && (state_r.wState == ctv_pkg::W_IDLE) && !state_r.wGot;
    assign s_axi_bvalid = (state_r.wState == ctv_pkg::W_RESP);
    assign s_axi_bresp = state_r.bResp;
    assign s_axi_arready = ce && (state_r.rState == ctv_pkg::R_IDLE);
    assign s_axi_rvalid = (state_r.rState == ctv_pkg::R_DATA);
    assign s_axi_rdata = state_r.rData;
    assign s_axi_rresp = state_r.rResp;

    // Core-side outputs come straight from flip-flops
    assign countValue = state_r.count;
    assign halted = state_r.halt;

    // Write to the value register launches the synchronizer unless protected
    assign wStart = ce && (state_r.wState == ctv_pkg::W_IDLE) && state_r.awGot && state_r.wGot
        && (state_r.awAddr == `CTV_VALUE_OFS) && !coreCfg.writeProtect;
    assign rStart = s_axi_arvalid && s_axi_arready;

    //------------------------------------------------------------
    // Synchronizer delay lines
    //------------------------------------------------------------

    ctv_sync #(.STAGES(WSYNC)) wSyncInst
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .reqIn(wStart),
        .reqOut(wLand)
    );

    ctv_sync #(.STAGES(RSYNC)) rSyncInst
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .reqIn(rStart),
        .reqOut(rLand)
    );

    //------------------------------------------------------------
    // Layout and halt decode
    //------------------------------------------------------------

    assign shift = fieldShift(coreCfg.resMode);
    assign mask = fieldMask(coreCfg.resMode);

    // Byte lanes 0..2 merge into the count; lane 3 is reserved and dropped
    always_comb
    begin
        merged = state_r.count;
        for (int b = 0; b < 3; b++)
        begin
            if (state_r.wStrb[b])
            begin
                merged[b*8 +: 8] = state_r.wData[b*8 +: 8];
            end
        end
        merged = merged & mask;
    end

    // Any of the three halting causes; set beats a same-cycle count step
    assign haltSet = !coreCfg.timerEnable || coreEvt.stopCmd
        || (coreEvt.updateEvt && coreCfg.singleRunMode);
    assign haltClr = coreEvt.countUp || coreEvt.countDown;

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------

    always_comb
    begin
        state_nxt = state_r;
        if (ce)
        begin
            // Halted flag
            if (haltSet)
            begin
                state_nxt.halt = 1'b1;
            end
            else if (haltClr)
            begin
                state_nxt.halt = 1'b0;
            end

            // Counting steps at the field's lowest bit; a landing bus write wins
            if (wLand)
            begin
                state_nxt.count = merged;
            end
            else if (coreEvt.countUp && !coreEvt.countDown)
            begin
                state_nxt.count = (state_r.count + (24'h000001 << shift)) & mask;
            end
            else if (coreEvt.countDown && !coreEvt.countUp)
            begin
                state_nxt.count = (state_r.count - (24'h000001 << shift)) & mask;
            end
            else
            begin
                state_nxt.count = state_r.count & mask;
            end

            // Write channel
            case (state_r.wState)
                ctv_pkg::W_IDLE:
                begin
                    if (s_axi_awvalid && s_axi_awready)
                    begin
                        state_nxt.awGot = 1'b1;
                        state_nxt.awAddr = s_axi_awaddr;
                    end
                    if (s_axi_wvalid && s_axi_wready)
                    begin
                        state_nxt.wGot = 1'b1;
                        state_nxt.wData = s_axi_wdata;
                        state_nxt.wStrb = s_axi_wstrb;
                    end
                    if (state_r.awGot && state_r.wGot)
                    begin
                        state_nxt.awGot = 1'b0;
                        state_nxt.wGot = 1'b0;
                        if (wStart)
                        begin
                            state_nxt.bResp = `CTV_RESP_OKAY;
                            state_nxt.wState = ctv_pkg::W_SYNC;
                        end
                        else if (state_r.awAddr == `CTV_STATUS_OFS)
                        begin
                            // Halted flag is hardware-owned; the write is dropped
                            state_nxt.bResp = `CTV_RESP_OKAY;
                            state_nxt.wState = ctv_pkg::W_RESP;
                        end
                        else
                        begin
                            // Protected value write or unmapped address
                            state_nxt.bResp = `CTV_RESP_SLVERR;
                            state_nxt.wState = ctv_pkg::W_RESP;
                        end
                    end
                end
                ctv_pkg::W_SYNC:
                begin
                    if (wLand)
                    begin
                        state_nxt.wState = ctv_pkg::W_RESP;
                    end
                end
                ctv_pkg::W_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        state_nxt.wState = ctv_pkg::W_IDLE;
                    end
                end
                default:
                begin
                    state_nxt.wState = ctv_pkg::W_IDLE;
                end
            endcase

            // Read channel; data is sampled when the synchronizer lands
            case (state_r.rState)
                ctv_pkg::R_IDLE:
                begin
                    if (rStart)
                    begin
                        state_nxt.arAddr = s_axi_araddr;
                        state_nxt.rState = ctv_pkg::R_SYNC;
                    end
                end
                ctv_pkg::R_SYNC:
                begin
                    if (rLand)
                    begin
                        state_nxt.rState = ctv_pkg::R_DATA;
                        state_nxt.rResp = `CTV_RESP_OKAY;
                        if (state_r.arAddr == `CTV_VALUE_OFS)
                        begin
                            state_nxt.rData = {8'h00, state_r.count & mask};
                        end
                        else if (state_r.arAddr == `CTV_STATUS_OFS)
                        begin
                            state_nxt.rData = 32'h00000000;
                            state_nxt.rData[`CTV_HALT_BIT] = state_r.halt;
                        end
                        else
                        begin
                            state_nxt.rData = 32'h00000000;
                            state_nxt.rResp = `CTV_RESP_SLVERR;
                        end
                    end
                end
                ctv_pkg::R_DATA:
                begin
                    if (s_axi_rready)
                    begin
                        state_nxt.rState = ctv_pkg::R_IDLE;
                    end
                end
                default:
                begin
                    state_nxt.rState = ctv_pkg::R_IDLE;
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------

    // Count clears to zero; halted starts set since the timer is not yet enabled
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_r <= '0;
            state_r.count <= `CTV_VALUE_RST;
            state_r.halt <= `CTV_HALT_RST;
            state_r.wState <= ctv_pkg::W_IDLE;
            state_r.rState <= ctv_pkg::R_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

endmodule

// ---- src/ctv_map.svh ----
// Register offsets, field positions, reset values and sync counts of the counter-value block
`ifndef CTV_MAP_SVH
`define CTV_MAP_SVH

// Register byte offsets
`define CTV_STATUS_OFS 8'h30
`define CTV_VALUE_OFS 8'h34

// Field positions
`define CTV_HALT_BIT 0
`define CTV_VALUE_MSB 23
`define CTV_SHIFT_NORMAL 5'h00
`define CTV_SHIFT_FOUR 5'h04
`define CTV_SHIFT_FIVE 5'h05
`define CTV_SHIFT_SIX 5'h06

// Reset values
`define CTV_VALUE_RST 24'h000000
`define CTV_HALT_RST 1'b1

// Crossing stages of the bus-side views
`define CTV_WSYNC_STAGES 2
`define CTV_RSYNC_STAGES 2

// Bus responses
`define CTV_RESP_OKAY 2'h0
`define CTV_RESP_SLVERR 2'h2

`endif

// ---- src/ctv_pkg.sv ----
// Types shared by the counter-value block
package ctv_pkg;

    // Resolution of the counter-value field
    typedef enum logic [1:0]
    {
        RES_NORMAL = 2'h0,
        RES_FOURBIT = 2'h1,
        RES_FIVEBIT = 2'h2,
        RES_SIXBIT = 2'h3
    } ctv_res_t;

    // Write channel states, Gray along idle, sync, response
    typedef enum logic [1:0]
    {
        W_IDLE = 2'h0,
        W_SYNC = 2'h1,
        W_RESP = 2'h3
    } ctv_wstate_t;

    // Read channel states, Gray along idle, sync, data
    typedef enum logic [1:0]
    {
        R_IDLE = 2'h0,
        R_SYNC = 2'h1,
        R_DATA = 2'h3
    } ctv_rstate_t;

    // Events from the counting core
    typedef struct packed
    {
        logic countUp;
        logic countDown;
        logic stopCmd;
        logic updateEvt;
    } ctv_core_evt_t;

    // Steady configuration from the counting core
    typedef struct packed
    {
        logic timerEnable;
        logic singleRunMode;
        logic writeProtect;
        ctv_res_t resMode;
    } ctv_core_cfg_t;

endpackage

// ---- src/ctv_sync.sv ----
// Pulse delay line that carries a request across the bus/counting synchronizer
`timescale 1ns/1ns

module ctv_sync
#(
    parameter int STAGES = 2
)
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Request in and delayed request out
    input wire logic reqIn,
    output logic reqOut
);

    typedef struct packed
    {
        logic [STAGES-1:0] pipe;
    } ctv_sync_state_t;

    ctv_sync_state_t state_r;
    ctv_sync_state_t state_nxt;

    // Shift the request one stage per enabled cycle
    always_comb
    begin
        state_nxt = state_r;
        if (ce)
        begin
            state_nxt.pipe[0] = reqIn;
            for (int i = 1; i < STAGES; i++)
            begin
                state_nxt.pipe[i] = state_r.pipe[i-1];
            end
        end
    end

    // Register the pipe
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign reqOut = state_r.pipe[STAGES-1];

endmodule

// ---- bench/ctv_top_sva.sv ----
// Port-level checker for the counter-value block
`timescale 1ns/1ns

module ctv_top_chk
#(
    parameter int WSYNC = 2,
    parameter int RSYNC = 2
)
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Bus handshakes
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // Counting core side
    input wire ctv_pkg::ctv_core_evt_t coreEvt,
    input wire ctv_pkg::ctv_core_cfg_t coreCfg,
    input wire logic [23:0] countValue,
    input wire logic halted
);
    // Answers rise one edge after the stated count, so they are sampled one later
    localparam int WLAT = WSYNC + 1;
    localparam int RLAT = RSYNC + 1;
    logic [23:0] lowMask;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ----
    // Field layout
    // ----
    // Low bits below the field in each dithering resolution
    assign lowMask = (coreCfg.resMode == ctv_pkg::RES_NORMAL) ? 24'h0
        : (24'h1 << (32'd3 + 32'(coreCfg.resMode))) - 24'h1;

    halt_set_a: assert property (ce && (!coreCfg.timerEnable || coreEvt.stopCmd
        || (coreEvt.updateEvt && coreCfg.singleRunMode)) |=> halted)
        else $error("halted flag not set");
    halt_clear_a: assert property (ce && coreCfg.timerEnable && !coreEvt.stopCmd && !coreEvt.updateEvt
        && (coreEvt.countUp || coreEvt.countDown) |=> !halted)
        else $error("halted flag not cleared");
    halt_hold_a: assert property (ce && coreCfg.timerEnable && coreEvt == 4'h0 |=> $stable(halted))
        else $error("halted flag moved without cause");
    // Idle write side means no landing bus write can override the step
    count_step_a: assert property (s_axi_awready && coreEvt.countUp && !coreEvt.countDown
        && coreCfg.resMode == ctv_pkg::RES_NORMAL |=> countValue == $past(countValue) + 24'h1)
        else $error("count did not step by one");
    field_mask_a: assert property ($stable(coreCfg.resMode) |-> (countValue & lowMask) == 24'h0)
        else $error("bits below field not clear");
    reserved_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
        else $error("upper byte not zero");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |-> ##RLAT s_axi_rvalid)
        else $error("read answer late");
    write_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == 8'h34 ##1 !coreCfg.writeProtect |-> ##WLAT s_axi_bvalid)
        else $error("write answer late");

    cover property (ce && coreEvt.stopCmd);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property (coreCfg.resMode == ctv_pkg::RES_SIXBIT && coreEvt.countUp);
endmodule

bind ctv_top ctv_top_chk #(.WSYNC(WSYNC), .RSYNC(RSYNC)) i_ctv_top_chk
(
    .sys_clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .coreEvt, .coreCfg, .countValue, .halted
);

// ---- bench/ctv_core_model.sv ----
// Stand-in for the counting core that feeds events and configuration
`timescale 1ns/1ns

module ctv_core_model
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Requests from the bench
    input wire ctv_pkg::ctv_core_evt_t evtReq,
    input wire ctv_pkg::ctv_core_cfg_t cfgReq,
    // Towards the block
    output ctv_pkg::ctv_core_evt_t coreEvt,
    output ctv_pkg::ctv_core_cfg_t coreCfg
);
    // Registered like a real core, so events land one edge after the request
    always_ff @(posedge sys_clk)
    begin
        coreEvt <= rst ? 4'h0 : evtReq;
        coreCfg <= cfgReq;
    end
endmodule

// ---- bench/ctv_top_tb.sv ----
// Self-checking bench for the counter-value block
`timescale 1ns/1ns

module ctv_top_tb;
    typedef struct packed
    {
        logic [1:0] res;
        logic [31:0] wd;
        logic [23:0] st;
    } ctv_row_t;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, halted;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic [23:0] countValue;
    ctv_pkg::ctv_core_evt_t evtReq = 4'h0;
    ctv_pkg::ctv_core_cfg_t cfgReq = 5'h0;
    ctv_pkg::ctv_core_evt_t coreEvt;
    ctv_pkg::ctv_core_cfg_t coreCfg;
    int errors = 0;
    int totalChecks = 0;
    // Mode, written word, count after one up step; last row wraps
    ctv_row_t rows[5] = '{'{2'h0, 32'h00A5C3E7, 24'hA5C3E8}, '{2'h1, 32'h00ABCDE0, 24'hABCDF0},
        '{2'h2, 32'h00FEDCA0, 24'hFEDCC0}, '{2'h3, 32'h00123440, 24'h123480}, '{2'h0, 32'h00FFFFFF, 24'h0}};
    // Enable, single-run, event nibble, halted after
    logic [6:0] hRows[7] = '{7'b10_0010_1, 7'b10_0100_0, 7'b10_0001_0, 7'b11_0001_1, 7'b11_1000_0,
        7'b01_0000_1, 7'b10_1010_1};

    always #5 sys_clk = ~sys_clk;

    ctv_core_model i_ctv_core_model (.sys_clk, .rst, .evtReq, .cfgReq, .coreEvt, .coreCfg);
    ctv_top i_ctv_top (.sys_clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .coreEvt, .coreCfg, .countValue, .halted);

    // ----
    // Shared tasks
    // ----
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Address and data go together; each is released once taken
    task axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        while (!s_axi_bvalid)
            @(posedge sys_clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge sys_clk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge sys_clk);
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // One event pulse; two more edges let it pass the stand-in and land
    task pulse(input logic [3:0] e);
        @(posedge sys_clk);
        evtReq <= e;
        @(posedge sys_clk);
        evtReq <= 4'h0;
        repeat (2)
            @(posedge sys_clk);
    endtask

    task complete_run;
        $display("checks %0d errors %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (16)
            @(posedge sys_clk);
        rst <= 1'b0;
        cfgReq.timerEnable <= 1'b1;
        chk("halted", 32'(halted), 32'h1);
        chk("count", 32'(countValue), 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            cfgReq.resMode <= ctv_pkg::ctv_res_t'(rows[i].res);
            axiWr(8'h34, rows[i].wd, resp);
            chk("wresp", 32'(resp), 32'h0);
            axiRd(8'h34, rd, resp);
            chk("count rd", rd, rows[i].wd);
            chk("rd resp", 32'(resp), 32'h0);
            chk("count pin", 32'(countValue), rows[i].wd);
            pulse(4'h8);
            chk("count step", 32'(countValue), 32'(rows[i].st));
        end
        for (int i = 0; i < 7; i++)
        begin
            cfgReq.timerEnable <= hRows[i][6];
            cfgReq.singleRunMode <= hRows[i][5];
            pulse(hRows[i][4:1]);
            chk("halted", 32'(halted), 32'(hRows[i][0]));
        end
        // Status is hardware-owned: the write is answered but the flag stays set
        axiWr(8'h30, 32'h0, resp);
        chk("status w", 32'(resp), 32'h0);
        axiRd(8'h30, rd, resp);
        chk("halt rd", rd, 32'h1);
        // A protected write must leave the earlier value
        axiWr(8'h34, 32'h55, resp);
        cfgReq.writeProtect <= 1'b1;
        axiWr(8'h34, 32'hAA, resp);
        chk("prot resp", 32'(resp), 32'h2);
        cfgReq.writeProtect <= 1'b0;
        axiRd(8'h34, rd, resp);
        chk("prot rd", rd, 32'h55);
        axiRd(8'h3C, rd, resp);
        chk("unmapped", {rd[31:2], resp}, 32'h2);
        axiWr(8'h3C, 32'h0, resp);
        chk("unmapped w", 32'(resp), 32'h2);
        // Only lane 1 is enabled, so the low byte keeps its earlier value
        s_axi_wstrb <= 4'h2;
        axiWr(8'h34, 32'h0000AA00, resp);
        s_axi_wstrb <= 4'hF;
        axiRd(8'h34, rd, resp);
        chk("lane rd", rd, 32'h0000AA55);
        ce <= 1'b0;
        pulse(4'h8);
        chk("frozen", 32'(countValue), 32'hAA55);
        ce <= 1'b1;
        pulse(4'h8);
        chk("count step", 32'(countValue), 32'hAA56);
        // Second reset in mid-run
        rst <= 1'b1;
        repeat (3)
            @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk("halted", 32'(halted), 32'h1);
        axiRd(8'h34, rd, resp);
        chk("count rd", rd, 32'h0);
        complete_run();
    end

    // Watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        #50000;
        errors++;
        complete_run();
    end
endmodule
